//--- logic/mdsp_pkg.sv
package mdsp_pkg;
  // 25 MHz clock
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BAUD_HZ = 115200;
  localparam int unsigned BIT_CYCLES = (CLK_HZ + BAUD_HZ / 2) / BAUD_HZ;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BIT_IDX_W = 4;
  // Line idles high
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [BIT_IDX_W-1:0] LAST_DATA_BIT = 4'h7;
  typedef enum logic [1:0] {
    MDSP_IDLE,
    MDSP_START,
    MDSP_DATA,
    MDSP_STOP
  } mdsp_state_t;
endpackage : mdsp_pkg

//--- logic/mdsp_buf2.sv
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer: full throughput, no combinational ready path
module mdsp_buf2 (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [7:0] mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : mdsp_buf2
`default_nettype wire

//--- logic/mdsp_top.sv
`timescale 1ns/1ps
`default_nettype none
module mdsp_top (
  input wire logic sys_clk,
  input wire logic reset,
  // Main port pins, named from the host side
  input wire logic txd_in,
  output logic rxd_out,
  output logic dcd_out,
  output logic dsr_out,
  output logic cts_out,
  output logic ring_out,
  input wire logic dtr_in,
  input wire logic rts_in,
  // Auxiliary port and shared SPI pins
  output logic tx_aux_mosi_out,
  input wire logic rx_aux_miso_in,
  input wire logic aux_sel,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Modem-side status
  input wire logic carrier_present,
  input wire logic device_ready,
  input wire logic call_incoming,
  output logic terminal_ready,
  // Main port byte streams
  input wire logic [7:0] main_tx_data,
  input wire logic main_tx_valid,
  output logic main_tx_ready,
  output logic [7:0] main_rx_data,
  output logic main_rx_valid,
  input wire logic main_rx_ready,
  // Auxiliary byte streams, then the main-port overrun flag
  input wire logic [7:0] aux_tx_data,
  input wire logic aux_tx_valid,
  output logic aux_tx_ready,
  output logic [7:0] aux_rx_data,
  output logic aux_rx_valid,
  input wire logic aux_rx_ready,
  output logic main_rx_overrun
);
  localparam int unsigned NP = 2;

  // Per-port line and stream signals; port 0 is main, port 1 auxiliary
  logic [NP-1:0] rx_line;
  logic [NP-1:0] tx_line;
  logic [NP-1:0] tx_allow;
  logic [NP-1:0] tx_valid;
  logic [NP-1:0] tx_ready;
  logic [7:0] tx_data [NP];
  logic [NP-1:0] rx_out_valid;
  logic [NP-1:0] rx_out_ready;
  logic [7:0] rx_out_data [NP];
  logic [NP-1:0] buf_in_ready;
  logic [NP-1:0] overrun;

  logic rts_reg;
  logic dtr_reg;
  logic rxd_reg;
  logic aux_tx_reg;
  logic dcd_reg;
  logic dsr_reg;
  logic ring_reg;
  logic cts_reg;
  logic term_reg;
  logic miso_reg;
  logic ovr_reg;

  assign rx_line[0] = txd_in;
  assign rx_line[1] = aux_sel ? rx_aux_miso_in : mdsp_pkg::LINE_IDLE;
  assign tx_allow[0] = rts_reg;
  assign tx_allow[1] = aux_sel;
  assign tx_valid[0] = main_tx_valid;
  assign tx_valid[1] = aux_tx_valid;
  assign tx_data[0] = main_tx_data;
  assign tx_data[1] = aux_tx_data;
  assign main_tx_ready = tx_ready[0];
  assign aux_tx_ready = tx_ready[1];
  assign main_rx_data = rx_out_data[0];
  assign main_rx_valid = rx_out_valid[0];
  assign rx_out_ready[0] = main_rx_ready;
  assign aux_rx_data = rx_out_data[1];
  assign aux_rx_valid = rx_out_valid[1];
  assign rx_out_ready[1] = aux_rx_ready;

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      mdsp_pkg::mdsp_state_t tx_state_reg;
      mdsp_pkg::mdsp_state_t rx_state_reg;
      logic [mdsp_pkg::CNT_W-1:0] tx_cnt_reg;
      logic [mdsp_pkg::CNT_W-1:0] rx_cnt_reg;
      logic [mdsp_pkg::BIT_IDX_W-1:0] tx_bit_reg;
      logic [mdsp_pkg::BIT_IDX_W-1:0] rx_bit_reg;
      logic [7:0] tx_sh_reg;
      logic [7:0] rx_sh_reg;
      logic tx_line_reg;
      logic rx_sync_reg;
      logic rx_push_reg;
      logic ovr_flag_reg;
      wire tx_tick = (tx_cnt_reg == 16'(mdsp_pkg::BIT_CYCLES - 1));
      wire rx_half = (rx_cnt_reg == 16'(mdsp_pkg::HALF_CYCLES - 1));
      wire rx_tick = (rx_cnt_reg == 16'(mdsp_pkg::BIT_CYCLES - 1));
      wire tx_take = (tx_state_reg == mdsp_pkg::MDSP_IDLE) && tx_valid[p] && tx_allow[p];

      // Bit position and counter steps
      wire tx_last = (tx_bit_reg == mdsp_pkg::LAST_DATA_BIT);
      wire tx_next_bit = tx_sh_reg[tx_bit_reg[2:0] + 3'h1];
      wire rx_last = (rx_bit_reg == mdsp_pkg::LAST_DATA_BIT);
      wire [mdsp_pkg::CNT_W-1:0] tx_cnt_next =
        (tx_take || tx_tick) ? 16'h0000 : tx_cnt_reg + 16'h0001;
      wire [mdsp_pkg::CNT_W-1:0] rx_cnt_step = rx_tick ? 16'h0000 : rx_cnt_reg + 16'h0001;

      assign tx_ready[p] = tx_take;
      assign tx_line[p] = tx_line_reg;
      assign overrun[p] = ovr_flag_reg;

      always_ff @(posedge sys_clk) begin
        if (reset) begin
          tx_state_reg <= mdsp_pkg::MDSP_IDLE;
          tx_cnt_reg <= 16'h0000;
          tx_bit_reg <= 4'h0;
          tx_sh_reg <= 8'h00;
          tx_line_reg <= mdsp_pkg::LINE_IDLE;
        end else begin
          tx_cnt_reg <= tx_cnt_next;
          unique case (tx_state_reg)
            mdsp_pkg::MDSP_IDLE: begin
              tx_line_reg <= mdsp_pkg::LINE_IDLE;
              if (tx_take) begin
                tx_sh_reg <= tx_data[p];
                tx_line_reg <= 1'b0;
                tx_state_reg <= mdsp_pkg::MDSP_START;
              end
            end
            mdsp_pkg::MDSP_START: begin
              if (tx_tick) begin
                tx_line_reg <= tx_sh_reg[0];
                tx_bit_reg <= 4'h0;
                tx_state_reg <= mdsp_pkg::MDSP_DATA;
              end
            end
            mdsp_pkg::MDSP_DATA: begin
              if (tx_tick) begin
                if (tx_last) begin
                  tx_line_reg <= 1'b1;
                  tx_state_reg <= mdsp_pkg::MDSP_STOP;
                end else begin
                  tx_line_reg <= tx_next_bit;
                  tx_bit_reg <= tx_bit_reg + 4'h1;
                end
              end
            end
            mdsp_pkg::MDSP_STOP: begin
              if (tx_tick) begin
                tx_state_reg <= mdsp_pkg::MDSP_IDLE;
              end
            end
          endcase
        end
      end

      always_ff @(posedge sys_clk) begin
        if (reset) begin
          rx_state_reg <= mdsp_pkg::MDSP_IDLE;
          rx_cnt_reg <= 16'h0000;
          rx_bit_reg <= 4'h0;
          rx_sh_reg <= 8'h00;
          rx_push_reg <= 1'b0;
        end else begin
          rx_push_reg <= 1'b0;
          unique case (rx_state_reg)
            mdsp_pkg::MDSP_IDLE: begin
              rx_cnt_reg <= 16'h0000;
              if (!rx_sync_reg) begin
                rx_state_reg <= mdsp_pkg::MDSP_START;
              end
            end
            mdsp_pkg::MDSP_START: begin
              rx_cnt_reg <= rx_cnt_reg + 16'h0001;
              if (rx_half) begin
                rx_cnt_reg <= 16'h0000;
                rx_bit_reg <= 4'h0;
                rx_state_reg <= rx_sync_reg ? mdsp_pkg::MDSP_IDLE : mdsp_pkg::MDSP_DATA;
              end
            end
            mdsp_pkg::MDSP_DATA: begin
              rx_cnt_reg <= rx_cnt_step;
              if (rx_tick) begin
                rx_sh_reg <= {rx_sync_reg, rx_sh_reg[7:1]};
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_last) begin
                  rx_state_reg <= mdsp_pkg::MDSP_STOP;
                end
              end
            end
            mdsp_pkg::MDSP_STOP: begin
              rx_cnt_reg <= rx_cnt_step;
              if (rx_tick) begin
                rx_push_reg <= rx_sync_reg;
                rx_state_reg <= mdsp_pkg::MDSP_IDLE;
              end
            end
          endcase
        end
      end

      // Line sampler and lost-byte flag
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          rx_sync_reg <= mdsp_pkg::LINE_IDLE;
          ovr_flag_reg <= 1'b0;
        end else begin
          rx_sync_reg <= rx_line[p];
          ovr_flag_reg <= rx_push_reg && !buf_in_ready[p];
        end
      end

      mdsp_buf2 u_buf (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_data(rx_sh_reg),
        .in_valid(rx_push_reg),
        .in_ready(buf_in_ready[p]),
        .out_data(rx_out_data[p]),
        .out_valid(rx_out_valid[p]),
        .out_ready(rx_out_ready[p])
      );
    end
  endgenerate

  // Control outputs registered to the pins; terminal_ready takes two register stages from dtr_in
  wire aux_tx_next = aux_sel ? tx_line[1] : spi_mosi;
  wire miso_next = aux_sel ? 1'b0 : rx_aux_miso_in;
  wire cts_next = !rx_out_valid[0];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rts_reg <= 1'b0;
    end else begin
      rts_reg <= rts_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dtr_reg <= 1'b0;
      term_reg <= 1'b0;
    end else begin
      dtr_reg <= dtr_in;
      term_reg <= dtr_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rxd_reg <= mdsp_pkg::LINE_IDLE;
    end else begin
      rxd_reg <= tx_line[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aux_tx_reg <= 1'b0;
      miso_reg <= 1'b0;
    end else begin
      aux_tx_reg <= aux_tx_next;
      miso_reg <= miso_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dcd_reg <= 1'b0;
      dsr_reg <= 1'b0;
      ring_reg <= 1'b0;
    end else begin
      dcd_reg <= carrier_present;
      dsr_reg <= device_ready;
      ring_reg <= call_incoming;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cts_reg <= 1'b0;
    end else begin
      cts_reg <= cts_next;
    end
  end

  // Lost-byte pulse to the pin
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ovr_reg <= 1'b0;
    end else begin
      ovr_reg <= overrun[0];
    end
  end

  assign rxd_out = rxd_reg;
  assign dcd_out = dcd_reg;
  assign dsr_out = dsr_reg;
  assign cts_out = cts_reg;
  assign ring_out = ring_reg;
  assign tx_aux_mosi_out = aux_tx_reg;
  assign spi_miso = miso_reg;
  assign terminal_ready = term_reg;
  assign main_rx_overrun = ovr_reg;
endmodule : mdsp_top
`default_nettype wire

//--- bench/mdsp_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mdsp_top_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic rxd_out,
  input wire logic dcd_out,
  input wire logic cts_out,
  input wire logic dtr_in,
  input wire logic rts_in,
  input wire logic tx_aux_mosi_out,
  input wire logic aux_sel,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic carrier_present,
  input wire logic terminal_ready,
  input wire logic main_tx_ready,
  input wire logic main_rx_valid,
  input wire logic aux_tx_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_start_bit;
    !rxd_out ##216 !rxd_out;
  endsequence
  AST_DCD: assert property (1'b1 |=> dcd_out == $past(carrier_present))
    else $error("carrier detect lag wrong");
  AST_TRM: assert property (1'b1 |-> ##2 terminal_ready == $past(dtr_in, 2))
    else $error("terminal ready lag wrong");
  AST_CTS_LOW: assert property (main_rx_valid [*2] |-> !cts_out)
    else $error("clear to send high with byte waiting");
  AST_CTS_HIGH: assert property (!main_rx_valid [*3] |-> cts_out)
    else $error("clear to send low with empty buffer");
  AST_RTS_GATE: assert property (main_tx_ready |-> $past(rts_in))
    else $error("main byte taken while request to send low");
  AST_AUX_GATE: assert property (aux_tx_ready |-> aux_sel)
    else $error("aux byte taken while pins belong to spi");
  AST_MAIN_START: assert property (main_tx_ready |-> ##2 s_start_bit)
    else $error("main start bit wrong");
  AST_MOSI: assert property (!aux_sel |=> tx_aux_mosi_out == $past(spi_mosi))
    else $error("shared pin does not follow spi data");
  AST_MISO: assert property (aux_sel |=> !spi_miso)
    else $error("spi input not blocked in aux mode");
endmodule : mdsp_top_chk
bind mdsp_top mdsp_top_chk chk_i (.*);
`default_nettype wire

//--- bench/mdsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module mdsp_host (
  input wire logic sys_clk,
  input wire logic ser_in,
  output logic ser_out
);
  localparam int B = mdsp_pkg::BIT_CYCLES;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial ser_out = 1'b1;
  // host frame out, self-paced at B clocks per bit
  task automatic send(input logic [7:0] b, input logic stop);
    logic [10:0] f;
    f = {1'b1, stop, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      ser_out <= f[i];
      repeat (B) @(posedge sys_clk);
    end
  endtask : send
  always begin
    @(negedge ser_in);
    repeat (B / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (B) @(posedge sys_clk);
      sh = {ser_in, sh[7:1]};
    end
    repeat (B) @(posedge sys_clk);
    if (ser_in === 1'b1) got_q.push_back(sh);
  end
endmodule : mdsp_host
`default_nettype wire

//--- bench/mdsp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mdsp_top_tb;
  localparam int B = mdsp_pkg::BIT_CYCLES;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic txd_in, rxd_out, dcd_out, dsr_out, cts_out, ring_out, dtr_in, rts_in, aux_sel;
  logic tx_aux_mosi_out, rx_aux_miso_in, spi_mosi, spi_miso, main_rx_overrun;
  logic carrier_present, device_ready, call_incoming, terminal_ready, ovr_seen;
  logic [7:0] main_tx_data, main_rx_data, aux_tx_data, aux_rx_data;
  logic main_tx_valid, main_tx_ready, main_rx_valid, main_rx_ready;
  logic aux_tx_valid, aux_tx_ready, aux_rx_valid, aux_rx_ready;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 sys_clk = ~sys_clk;
  mdsp_top uut (.*);
  mdsp_host host_m (.sys_clk(sys_clk), .ser_in(rxd_out), .ser_out(txd_in));
  mdsp_host host_a (.sys_clk(sys_clk), .ser_in(tx_aux_mosi_out), .ser_out(rx_aux_miso_in));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // Caller lowers valid, so back-to-back bytes keep it high
  task automatic put(input logic aux, input logic [7:0] b);
    int n;
    n = 0;
    main_tx_data <= b;
    aux_tx_data <= b;
    if (aux) aux_tx_valid <= 1'b1;
    else main_tx_valid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((aux ? aux_tx_ready : main_tx_ready) !== 1'b1 && n < 3000);
  endtask : put
  task automatic get(input logic aux, input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((aux ? aux_rx_valid : main_rx_valid) !== 1'b1 && n < 5000);
    chk("rx_data", aux ? aux_rx_data : main_rx_data, exp);
    if (aux) aux_rx_ready <= 1'b1;
    else main_rx_ready <= 1'b1;
    @(posedge sys_clk);
    aux_rx_ready <= 1'b0;
    main_rx_ready <= 1'b0;
  endtask : get
  task automatic t_status;
    for (int i = 0; i < 16; i++) begin
      {carrier_present, device_ready, call_incoming, dtr_in} <= i[3:0];
      tick(3);
      chk("status", {4'h0, dcd_out, dsr_out, ring_out, terminal_ready}, i[7:0]);
    end
  endtask : t_status
  task automatic t_tx;
    rts_in <= 1'b0;
    main_tx_data <= 8'h5a;
    main_tx_valid <= 1'b1;
    tick(300);
    chk("idle_rts", 8'(rxd_out), 8'h01);
    rts_in <= 1'b1;
    put(1'b0, 8'h5a);
    put(1'b0, 8'h81);
    main_tx_valid <= 1'b0;
    rts_in <= 1'b0;
    tick(B * 12);
    chk("host_cnt", 8'(host_m.got_q.size()), 8'h02);
    chk("tx0", host_m.got_q.pop_front(), 8'h5a);
    chk("tx1", host_m.got_q.pop_front(), 8'h81);
    rts_in <= 1'b1;
  endtask : t_tx
  task automatic t_rx;
    host_m.send(8'h77, 1'b0);
    chk("bad_stop", 8'(cts_out), 8'h01);
    host_m.send(8'h3c, 1'b1);
    chk("cts_wait", 8'(cts_out), 8'h00);
    host_m.send(8'hc3, 1'b1);
    host_m.send(8'h99, 1'b1);
    chk("overrun", 8'(ovr_seen), 8'h01);
    get(1'b0, 8'h3c);
    get(1'b0, 8'hc3);
    tick(4);
    chk("cts_back", 8'(cts_out), 8'h01);
  endtask : t_rx
  task automatic t_aux;
    host_a.got_q.delete();
    aux_sel <= 1'b1;
    tick(3);
    chk("miso_off", 8'(spi_miso), 8'h00);
    put(1'b1, 8'hc6);
    aux_tx_valid <= 1'b0;
    host_a.send(8'h6c, 1'b1);
    get(1'b1, 8'h6c);
    tick(B * 2);
    chk("aux_tx", host_a.got_q.pop_front(), 8'hc6);
    aux_sel <= 1'b0;
    spi_mosi <= 1'b0;
    aux_tx_valid <= 1'b1;
    tick(3);
    chk("mosi", 8'(tx_aux_mosi_out), 8'h00);
    chk("miso", 8'(spi_miso), 8'h01);
    aux_tx_valid <= 1'b0;
    spi_mosi <= 1'b1;
    tick(2);
  endtask : t_aux
  always @(posedge sys_clk) begin
    cyc++;
    if (main_rx_overrun === 1'b1) ovr_seen = 1'b1;
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    {dtr_in, rts_in, aux_sel, carrier_present, device_ready, call_incoming} = '0;
    {main_tx_valid, main_rx_ready, aux_tx_valid, aux_rx_ready, ovr_seen} = '0;
    {main_tx_data, aux_tx_data} = '0;
    spi_mosi = 1'b1;
    tick(4);
    reset <= 1'b0;
    tick(2);
    t_status();
    t_tx();
    t_rx();
    t_aux();
    close_out();
  end
endmodule : mdsp_top_tb
`default_nettype wire
